// [scbs_params.svh]
// Constants for the serial configuration bitstream source
`ifndef SCBS_PARAMS_SVH
`define SCBS_PARAMS_SVH
`define SCBS_CLK_HZ 125000000
`define SCBS_POR_MS 100
`define SCBS_POR_CYCLES ((`SCBS_POR_MS * 64'd125000000) / 64'd1000)
`define SCBS_TAIL_CLOCKS 16
`define SCBS_ADDR_W 10
`define SCBS_DEPTH 1024
`endif

// [scbs_pkg.sv]
// Types for the serial configuration bitstream source
package scbs_pkg;
    typedef enum logic [2:0] {
        SCBS_POR,
        SCBS_SEND,
        SCBS_WAIT_DONE,
        SCBS_TAIL,
        SCBS_IDLE,
        SCBS_ERROR
    } scbs_state_t;
endpackage

// [scbs_edge_if.sv]
// Carrier between the sampler and the sequencer
`timescale 1ns/100ps
interface scbs_edge_if;
    logic clk_rise;
    logic cs_n_s;
    logic oe_s;
    logic done_s;
    modport src (output clk_rise, output cs_n_s, output oe_s, output done_s);
    modport dst (input clk_rise, input cs_n_s, input oe_s, input done_s);
endinterface

// [scbs_sampler.sv]
// Two-flop synchronisers and config clock rising-edge finder
`timescale 1ns/100ps
module scbs_sampler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic config_clock,
    input wire logic chip_select_n,
    input wire logic oe_in,
    input wire logic target_done,
    scbs_edge_if.src e
);
    logic [3:0] s1;
    logic [3:0] s2;
    logic clk_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= 4'h6;
            s2 <= 4'h6;
        end else begin
            s1 <= {target_done, oe_in, chip_select_n, config_clock};
            s2 <= s1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= s2[0];
        end
    end

    assign e.clk_rise = s2[0] & ~clk_q;
    assign e.cs_n_s = s2[1];
    assign e.oe_s = s2[2];
    assign e.done_s = s2[3];
endmodule

// [scbs_top.sv]
// Serial configuration bitstream source sequencer
// Summary of operation
// [RQ1] Data output floats while unselected before config and after all data sent.
// [RQ2] Each config clock rising edge advances address and presents next bit.
// [RQ3] Counting only with enable high, select low, data not exhausted.
// [RQ4] Low enable-reset line clears the address counter to start.
// [RQ5] High enable-reset line drives data and lets the counter count.
// [RQ6] Low chip select enables data and lets clock edges count.
// [RQ7] Chain-next select goes low once address reaches maximum.
// [RQ8] In external mode the target supplies the config clock.
// [RQ9] Internal power-up delay lasts at most 100 ms before configuration.
// [RQ10] Target-provided power-up delay is typically 100 ms, at most 200 ms.
// [RQ11] Error checking runs only in self-clocked mode, not external mode.
// [RQ12] Error if target done stays low after all data sent.
// [RQ13] Error if target done rises before all data sent.
// [RQ14] On error pull enable-reset line low to flag the target.
// [RQ15] With auto-restart set, start a new attempt after an error.
// [RQ16] Target checks CRC and may pull its error line low.
// [RQ17] Target pulling the shared line low resets the device.
// [RQ18] After done, first device issues 16 more clocks then idles.
// [RQ19] In external mode the target holds enable high and clocks.
// [RQ20] After maximum, hold chain-next low and stop until enable reset.
`timescale 1ns/100ps
`include "scbs_params.svh"
module scbs_top #(
    parameter int ADDR_W = `SCBS_ADDR_W,
    parameter int DEPTH = `SCBS_DEPTH,
    parameter longint POR_CYCLES = `SCBS_POR_CYCLES,
    parameter logic [DEPTH-1:0] IMAGE = '0
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CONFIG_CLOCK_IN,
    output logic CONFIG_CLOCK_OUT,
    output logic CONFIG_CLOCK_OE,
    input wire logic CHIP_SELECT_N,
    input wire logic OE_IN,
    output logic OE_OUT,
    output logic OE_OE,
    input wire logic TARGET_DONE,
    output logic DATA_OUT,
    output logic DATA_OE,
    output logic CHAIN_NEXT_SELECT_N,
    input wire logic SELF_CLOCKED,
    input wire logic FIRST_IN_CHAIN,
    input wire logic AUTO_RESTART,
    output logic ERROR_FLAG
);
    scbs_edge_if e ();
    scbs_pkg::scbs_state_t state;
    logic [ADDR_W-1:0] addr;
    logic [63:0] por_cnt;
    logic [4:0] tail_cnt;
    logic [2:0] div;
    logic at_max;
    logic spent;
    logic run;
    logic mem [DEPTH];
    logic err_set;
    logic oe_low;

    scbs_sampler u_smp (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .config_clock(CONFIG_CLOCK_IN),
        .chip_select_n(CHIP_SELECT_N),
        .oe_in(OE_IN),
        .target_done(TARGET_DONE),
        .e(e)
    );

    // Stored image held as an array so a bench can load it via IMAGE
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_mem
            assign mem[gi] = IMAGE[gi];
        end
    endgenerate

    assign at_max = (addr == ADDR_W'(DEPTH - 1));
    assign oe_low = ~e.oe_s;
    // Counting needs OE high, select low and data not yet exhausted
    assign run = e.clk_rise & e.oe_s & ~e.cs_n_s & ~spent &
        (state != scbs_pkg::SCBS_ERROR); // RQ3 RQ5 RQ6

    // Self-clocked mode divides the core clock by 8 for the config clock
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            div <= 3'h0;
        end else begin
            div <= div + 3'h1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            CONFIG_CLOCK_OUT <= 1'b0;
        end else begin
            CONFIG_CLOCK_OUT <= div[2];
        end
    end

    // External mode: clock pin is input only
    assign CONFIG_CLOCK_OE = SELF_CLOCKED & FIRST_IN_CHAIN &
        ((state == scbs_pkg::SCBS_SEND) | (state == scbs_pkg::SCBS_WAIT_DONE) |
         (state == scbs_pkg::SCBS_TAIL)); // RQ8

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            addr <= '0;
        end else if (oe_low | (state == scbs_pkg::SCBS_ERROR)) begin
            addr <= '0; // RQ4 RQ17
        end else if (run & ~at_max) begin
            addr <= addr + ADDR_W'(1); // RQ2 RQ20
        end
    end

    // Terminal count sits one past the last address, so the final bit is
    // still driven while the target samples it
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            spent <= 1'b0;
        end else if (oe_low | (state == scbs_pkg::SCBS_ERROR)) begin
            spent <= 1'b0; // RQ4
        end else if (run & at_max) begin
            spent <= 1'b1; // RQ3 RQ20
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            DATA_OUT <= 1'b0;
        end else begin
            DATA_OUT <= mem[addr]; // RQ2
        end
    end

    // Float while unselected or once the image is exhausted
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            DATA_OE <= 1'b0;
        end else begin
            DATA_OE <= e.oe_s & ~e.cs_n_s & ~spent; // RQ1 RQ5 RQ6
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            CHAIN_NEXT_SELECT_N <= 1'b1;
        end else begin
            CHAIN_NEXT_SELECT_N <= ~spent; // RQ7 RQ20
        end
    end

    // Errors only checked in self-clocked mode
    assign err_set = SELF_CLOCKED & FIRST_IN_CHAIN & (
        ((state == scbs_pkg::SCBS_SEND) & ~spent & e.cs_n_s & e.done_s) | // RQ13
        ((state == scbs_pkg::SCBS_WAIT_DONE) & e.clk_rise & ~e.cs_n_s)); // RQ11 RQ12

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state <= scbs_pkg::SCBS_POR;
            por_cnt <= '0;
            tail_cnt <= '0;
        end else begin
            case (state)
                scbs_pkg::SCBS_POR: begin
                    por_cnt <= por_cnt + 64'd1;
                    if (por_cnt >= 64'(POR_CYCLES - 1)) begin
                        state <= scbs_pkg::SCBS_SEND; // RQ9
                    end
                end
                scbs_pkg::SCBS_SEND: begin
                    if (err_set) begin
                        state <= scbs_pkg::SCBS_ERROR; // RQ13
                    end else if (spent) begin
                        state <= scbs_pkg::SCBS_WAIT_DONE;
                    end
                end
                scbs_pkg::SCBS_WAIT_DONE: begin
                    tail_cnt <= '0;
                    if (err_set) begin
                        state <= scbs_pkg::SCBS_ERROR; // RQ12
                    end else if (e.cs_n_s) begin
                        state <= scbs_pkg::SCBS_TAIL;
                    end else if (oe_low) begin
                        state <= scbs_pkg::SCBS_SEND;
                    end
                end
                scbs_pkg::SCBS_TAIL: begin
                    if (e.clk_rise) begin
                        tail_cnt <= tail_cnt + 5'h01;
                    end
                    if (tail_cnt == 5'(`SCBS_TAIL_CLOCKS)) begin
                        state <= scbs_pkg::SCBS_IDLE; // RQ18
                    end
                end
                scbs_pkg::SCBS_IDLE: begin
                    if (oe_low) begin
                        state <= scbs_pkg::SCBS_SEND;
                    end
                end
                scbs_pkg::SCBS_ERROR: begin
                    if (AUTO_RESTART) begin
                        state <= scbs_pkg::SCBS_SEND; // RQ15
                    end
                end
                default: begin
                    state <= scbs_pkg::SCBS_POR;
                end
            endcase
        end
    end

    // Line is pulled low during the power-up delay and on error; an external low also resets
    assign OE_OUT = 1'b0;
    assign OE_OE = (state == scbs_pkg::SCBS_ERROR) | (state == scbs_pkg::SCBS_POR); // RQ14
    assign ERROR_FLAG = (state == scbs_pkg::SCBS_ERROR);

    property p_reset_addr;
        @(posedge CORE_CLK) disable iff (!RST_N) oe_low |=> addr == '0;
    endproperty
    a_reset_addr: assert property (p_reset_addr) // RQ4
        else $error("address not cleared by low enable");
    property p_casc;
        @(posedge CORE_CLK) disable iff (!RST_N) spent |=> !CHAIN_NEXT_SELECT_N;
    endproperty
    a_casc: assert property (p_casc) else $error("chain select not low"); // RQ7
    property p_float;
        @(posedge CORE_CLK) disable iff (!RST_N) e.cs_n_s |=> !DATA_OE;
    endproperty
    a_float: assert property (p_float) else $error("data driven while unselected"); // RQ1
    property p_err_pull;
        @(posedge CORE_CLK) disable iff (!RST_N) err_set |=> OE_OE;
    endproperty
    a_err_pull: assert property (p_err_pull) else $error("enable not pulled on error"); // RQ14
    property p_oe_float;
        @(posedge CORE_CLK) disable iff (!RST_N) oe_low |=> !DATA_OE;
    endproperty
    a_oe_float: assert property (p_oe_float) else $error("data driven while enable low"); // RQ5
    property p_step;
        @(posedge CORE_CLK) disable iff (!RST_N)
            run & ~at_max & ~oe_low |=> addr == $past(addr) + ADDR_W'(1);
    endproperty
    a_step: assert property (p_step) else $error("address did not step"); // RQ2
    property p_hold_max;
        @(posedge CORE_CLK) disable iff (!RST_N)
            spent & ~oe_low & (state != scbs_pkg::SCBS_ERROR) |=> $stable(addr);
    endproperty
    a_hold_max: assert property (p_hold_max) else $error("address moved after end"); // RQ20
    property p_restart;
        @(posedge CORE_CLK) disable iff (!RST_N)
            (state == scbs_pkg::SCBS_ERROR) & AUTO_RESTART |=> state == scbs_pkg::SCBS_SEND;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart after error"); // RQ15
    c_tail: cover property (@(posedge CORE_CLK) state == scbs_pkg::SCBS_IDLE);
    c_err: cover property (@(posedge CORE_CLK) state == scbs_pkg::SCBS_ERROR);
    c_max: cover property (@(posedge CORE_CLK) at_max);
endmodule

// [scbs_target_model.sv]
// Target model: config clock source, bit capture, enable line pull
`timescale 1ns/100ps
module scbs_target_model (
    input wire logic run,
    input wire logic clr,
    input wire logic pull,
    input wire logic data_wire,
    output logic config_clock,
    output logic oe_pull,
    output logic [15:0] cap,
    output int cnt
);
    assign oe_pull = pull;
    // Clock stands low outside frames; odd start keeps it off the core phase
    initial begin
        config_clock = 1'b0;
        #5;
        forever begin
            #32;
            config_clock = run ? ~config_clock : 1'b0;
        end
    end
    always @(posedge config_clock or posedge clr) begin
        if (clr) begin
            cnt <= 0;
        end else begin
            if (cnt < 16) begin
                cap[cnt[3:0]] <= data_wire;
            end
            cnt <= cnt + 1;
        end
    end
endmodule

// [tb_scbs_top.sv]
// Self-checking bench for the bitstream source
`timescale 1ns/100ps
module tb_scbs_top;
    localparam logic [15:0] IMG = 16'hA5C3;
    logic clk, rst_n, cfg_in, cfg_out, cfg_oe, cs_n, oe_in, oe_out, oe_oe, done;
    logic dout, doe, casc_n, self_clk, auto_rst, err, run, clr, pull, mclk, mpull, first;
    logic [15:0] cap;
    int cnt, bad_count, n_checks, tail_n;
    assign cfg_in = cfg_oe ? cfg_out : mclk;
    // Open-drain enable line with pull-up: the design's driven level matters
    assign oe_in = (oe_oe ? oe_out : 1'b1) & ~mpull;
    scbs_top #(.ADDR_W(4), .DEPTH(16), .POR_CYCLES(20), .IMAGE(IMG)) i_dut (
        .CORE_CLK(clk), .RST_N(rst_n), .CONFIG_CLOCK_IN(cfg_in),
        .CONFIG_CLOCK_OUT(cfg_out), .CONFIG_CLOCK_OE(cfg_oe), .CHIP_SELECT_N(cs_n),
        .OE_IN(oe_in), .OE_OUT(oe_out), .OE_OE(oe_oe), .TARGET_DONE(done),
        .DATA_OUT(dout), .DATA_OE(doe), .CHAIN_NEXT_SELECT_N(casc_n),
        .SELF_CLOCKED(self_clk), .FIRST_IN_CHAIN(first), .AUTO_RESTART(auto_rst),
        .ERROR_FLAG(err));
    // Released data line shows the inverse of the last bit so a stale bit cannot pass
    scbs_target_model i_tgt (.run(run), .clr(clr), .pull(pull),
        .data_wire(doe ? dout : ~dout), .config_clock(mclk), .oe_pull(mpull),
        .cap(cap), .cnt(cnt));
    always @(posedge cfg_in) tail_n++;
    task automatic chk(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s exp %b got %b", what, exp, got);
        end
    endtask
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic boot(input logic sc, input logic ar);
        self_clk = sc;
        auto_rst = ar;
        rst_n = 0;
        cyc(5);
        rst_n = 1;
        for (int i = 0; i < 60 && oe_oe !== 1'b0; i++) cyc(1);
        chk("power-up delay over", 1'b0, oe_oe);
    endtask
    task automatic edges(input int n);
        clr = 1;
        cyc(1);
        clr = 0;
        run = 1;
        for (int i = 0; i < 400 && cnt < n; i++) cyc(1);
        run = 0;
        cyc(12);
    endtask
    task automatic t_unselected();
        cs_n = 1;
        boot(0, 0);
        edges(3);
        chk("data_oe unselected", 1'b0, doe);
        cs_n = 0;
        cyc(4);
        chk("data_oe selected", 1'b1, doe);
        edges(16);
        chk16("stream after refused edges", IMG, cap);
        $display("test unselected done");
    endtask
    task automatic t_stream();
        boot(0, 0);
        edges(5);
        pull = 1;
        cyc(4);
        chk("data_oe enable low", 1'b0, doe);
        pull = 0;
        cyc(4);
        edges(16);
        chk16("stream after line reset", IMG, cap);
        chk("casc_n at max", 1'b0, casc_n);
        edges(3);
        chk("casc_n held", 1'b0, casc_n);
        chk("no error external", 1'b0, err);
        pull = 1;
        cyc(4);
        pull = 0;
        cyc(4);
        chk("casc_n cleared", 1'b1, casc_n);
        $display("test stream done");
    endtask
    task automatic t_early();
        first = 1'b0;
        boot(1, 0);
        cs_n = 1;
        done = 1;
        cyc(30);
        chk("no error when chained", 1'b0, err);
        chk("no clock when chained", 1'b0, cfg_oe);
        cs_n = 0;
        done = 0;
        first = 1'b1;
        boot(1, 0);
        cyc(10);
        cs_n = 1;
        done = 1;
        for (int i = 0; i < 40 && err !== 1'b1; i++) cyc(1);
        chk("error early done", 1'b1, err);
        chk("enable pulled", 1'b1, oe_oe);
        chk("enable pulled level", 1'b0, oe_out);
        cyc(50);
        chk("no restart", 1'b1, err);
        cs_n = 0;
        done = 0;
        $display("test early done");
    endtask
    task automatic t_tail();
        boot(1, 0);
        for (int i = 0; i < 400 && casc_n !== 1'b0; i++) cyc(1);
        // Done has to follow within one config clock of the last bit
        cyc(2);
        cs_n = 1;
        done = 1;
        tail_n = 0;
        cyc(400);
        chk("tail clocks", 1'b1, tail_n inside {16, 17});
        chk("idle clock off", 1'b0, cfg_oe);
        chk("no error tail", 1'b0, err);
        cs_n = 0;
        done = 0;
        $display("test tail done");
    endtask
    task automatic t_late();
        boot(1, 1);
        for (int i = 0; i < 2000 && err !== 1'b1; i++) cyc(1);
        chk("error late done", 1'b1, err);
        chk("casc_n at error", 1'b0, casc_n);
        for (int i = 0; i < 100 && err !== 1'b0; i++) cyc(1);
        chk("auto restart", 1'b0, err);
        $display("test late done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        results();
    end
    initial begin
        {rst_n, cs_n, done, self_clk, auto_rst, run, clr, pull} = 8'h00;
        first = 1'b1;
        t_unselected();
        t_stream();
        t_early();
        t_tail();
        t_late();
        results();
    end
endmodule
